// >>> rtl/flash_write_protect_status.v
// Notes on behaviour
// RL1: below write-inhibit threshold the device stays reset and decodes nothing.
// RL2: during power-up write delay, write-related instructions including write enable are rejected.
// RL3: power-up completes with the write-enable latch cleared.
// RL4: program, erase and status write need the write-enable latch set.
// RL5: finishing program, erase or status write clears the write-enable latch.
// RL6: in power-down only the release instruction is obeyed.
// RL7: 510 block locks plus 32 sector locks in the end blocks.
// RL8: a set lock blocks program and erase of its region; clear lock allows.
// RL9: all lock bits are set at power-on.
// RL10: the unlock instruction clears the lock bit of the addressed region.
// RL11: scheme select 0 uses block-protect fields, 1 uses individual locks only.
// RL12: status writes gated by protect bits, latch, and write-protect pin outside quad.
// RL13: busy flag in bit 0; while busy only status read and suspend accepted.
// RL14: busy flag clears when the operation completes.
// RL15: latch shown in bit 1; set by write enable, cleared by disable and writes.
// RL16: four block-protect bits in bits 5..2, written by status write, default 0.
// RL17: top/bottom select 0 protects from top, 1 from bottom, default 0.
// RL18: complement bit in bit 14 inverts the selected protected region.
// RL19: protect bits 00: status writable whenever latch set, pin ignored.
// RL20: protect bits 01: pin low blocks status writes, pin high allows with latch.
// RL21: protect bits 10: status writes refused until power cycle, which returns 00.
// RL22: protect bits 11: status writes refused permanently.
// RL23: device reset also sets every lock bit.
// RL24: rejected writes change nothing and start no busy period.
`timescale 1ns/1ps
`include "flash_wp_defines.vh"

module flash_write_protect_status #(
   parameter PU_DELAY_CYC = `PU_WRITE_DELAY_CYC
) (
   input wire clk_sys, // system clock, 100 MHz
   input wire rstn, // synchronous reset, active low
   input wire supply_ok, // supply above write_inhibit_threshold
   input wire cs_n, // serial chip select, active low
   input wire sclk, // serial clock from host
   input wire mosi, // serial data in
   input wire wp_n, // write-protect pin, active low
   input wire protect_scheme_select, // 1 selects individual locks
   input wire op_done, // array engine finished current operation
   output wire miso, // serial data out
   output wire miso_oe, // data out driven
   output wire op_start, // one-cycle start to array engine
   output wire [2:0] op_kind, // kind of operation started
   output wire [31:0] op_addr, // address of operation started
   output wire suspend_req, // one-cycle suspend request
   output wire busy, // operation in progress
   output wire [7:0] status_one, // live status_one
   output wire [7:0] status_two // live status_two
);

   localparam ST_OFF = 2'h0;
   localparam ST_READY = 2'h1;
   localparam ST_BUSY = 2'h2;
   localparam ST_SLEEP = 2'h3;
   localparam [31:0] PU_LAST = PU_DELAY_CYC - 1;

   // synchronisers: first stage read only by the second
   reg [5:0] in_m_r;
   reg [5:0] in_s_r;
   reg sclk_p_r;
   reg cs_p_r;

   wire vcc_s = in_s_r[5];
   wire cs_s = in_s_r[4];
   wire sclk_s = in_s_r[3];
   wire mosi_s = in_s_r[2];
   wire wp_s = in_s_r[1];
   wire wps_s = in_s_r[0];

   reg [1:0] state_r;
   reg pu_lock_r;
   reg [31:0] pu_cnt_r;
   reg wel_r;
   reg [3:0] bp_r;
   reg tb_r;
   reg cmp_r;
   reg qe_r;
   reg srp_low_r;
   reg srp_high_r;
   reg rst_armed_r;

   reg [2:0] bit_cnt_r;
   reg [2:0] byte_cnt_r;
   reg [7:0] shift_r;
   reg [7:0] opcode_r;
   reg [31:0] addr_r;
   reg [7:0] data1_r;
   reg [7:0] data2_r;
   reg rd_active_r;
   reg rd_sel_r;
   reg [7:0] out_sh_r;

   reg miso_r;
   reg miso_oe_r;
   reg op_start_r;
   reg [2:0] op_kind_r;
   reg [31:0] op_addr_r;
   reg suspend_r;
   reg [7:0] status_one_r;
   reg [7:0] status_two_r;

   reg lock_set_all;
   reg lock_unlock;
   reg lock_lock;
   wire region_locked;
   wire any_locked;

   wire busy_flag = (state_r == ST_BUSY); // RL13
   wire [7:0] sr1 = {srp_low_r, tb_r, bp_r, wel_r, busy_flag}; // RL15 RL16
   wire [7:0] sr2 = {1'b0, cmp_r, 4'h0, qe_r, srp_high_r}; // RL18 RL19

   wire sclk_rise = sclk_s & ~sclk_p_r;
   wire sclk_fall = ~sclk_s & sclk_p_r;
   wire cs_rise = cs_s & ~cs_p_r;
   wire selected = ~cs_s;
   wire [7:0] byte_nxt = {shift_r[6:0], mosi_s};
   wire byte_done = sclk_rise & selected & (bit_cnt_r == 3'h7);
   // only whole-byte frames execute; a torn last byte aborts the command
   wire cmd_end = cs_rise & (bit_cnt_r == 3'h0) & (byte_cnt_r != 3'h0);
   wire has_addr = (byte_cnt_r >= 3'h5);

   // block-protect region, one 64KB block granule
   function bp_hit;
      input [3:0] bp;
      input tb;
      input [8:0] blk;
      reg [9:0] n;
      begin
         if (bp > 4'h9) begin
            n = 10'h200;
         end else begin
            n = 10'h001 << (bp - 4'h1);
         end
         if (bp == 4'h0) begin
            bp_hit = 1'b0;
         end else if (tb) begin
            bp_hit = ({1'b0, blk} < n); // RL17
         end else begin
            bp_hit = ({1'b0, blk} >= (10'h200 - n)); // RL17
         end
      end
   endfunction

   wire bp_prot = cmp_r ^ bp_hit(bp_r, tb_r, addr_r[24:16]); // RL18
   wire region_prot = wps_s ? region_locked : bp_prot; // RL11
   wire chip_prot = wps_s ? any_locked : ((bp_r != 4'h0) | cmp_r); // RL11
   wire [1:0] srp = {srp_high_r, srp_low_r};
   // pin only qualifies in standard/dual use; with quad enabled it is data
   wire sr_write_ok = wel_r & ((srp == 2'h0) |
                      ((srp == 2'h1) & (qe_r | wp_s))); // RL12 RL19 RL20 RL21 RL22

   block_lock_store u_locks (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .set_all(lock_set_all),
      .unlock(lock_unlock),
      .lock(lock_lock),
      .addr(addr_r[24:0]),
      .locked(region_locked),
      .any_locked(any_locked)
   ); // RL7

   always @(posedge clk_sys) begin
      if (!rstn) begin
         // reset image matches idle pins (sclk low), so no false edge follows reset
         in_m_r <= 6'h12;
         in_s_r <= 6'h12;
         sclk_p_r <= 1'b0;
         cs_p_r <= 1'b1;
      end else begin
         in_m_r <= {supply_ok, cs_n, sclk, mosi, wp_n, protect_scheme_select};
         in_s_r <= in_m_r;
         sclk_p_r <= sclk_s;
         cs_p_r <= cs_s;
      end
   end

   // serial frame capture and status readout
   always @(posedge clk_sys) begin
      if (!rstn || !vcc_s || cs_s) begin
         bit_cnt_r <= 3'h0;
         rd_active_r <= 1'b0;
         miso_oe_r <= 1'b0;
         if (!rstn || !vcc_s) begin
            byte_cnt_r <= 3'h0;
            shift_r <= 8'h00;
            opcode_r <= 8'h00;
            addr_r <= 32'h0000_0000;
            data1_r <= 8'h00;
            data2_r <= 8'h00;
            rd_sel_r <= 1'b0;
            out_sh_r <= 8'h00;
            miso_r <= 1'b0;
         end else if (cs_rise) begin
            byte_cnt_r <= byte_cnt_r;
         end else begin
            // idle: next frame starts clean
            byte_cnt_r <= 3'h0;
         end
      end else begin
         if (byte_cnt_r == 3'h0 && bit_cnt_r == 3'h0 && !sclk_rise) begin
            addr_r <= addr_r;
         end
         if (sclk_rise) begin
            shift_r <= byte_nxt;
            bit_cnt_r <= bit_cnt_r + 3'h1;
         end
         if (byte_done) begin
            if (byte_cnt_r != 3'h7) begin
               byte_cnt_r <= byte_cnt_r + 3'h1;
            end
            if (byte_cnt_r == 3'h0) begin
               opcode_r <= byte_nxt;
               // RL6: no readout while asleep (ST_SLEEP); every other state, ST_OFF included, allows it
               if ((byte_nxt == `OP_RD_STAT1 || byte_nxt == `OP_RD_STAT2) &&
                   state_r != ST_SLEEP) begin
                  rd_active_r <= 1'b1;
                  rd_sel_r <= (byte_nxt == `OP_RD_STAT2);
                  out_sh_r <= (byte_nxt == `OP_RD_STAT2) ? sr2 : sr1;
               end
            end else begin
               if (byte_cnt_r <= 3'h4) begin
                  addr_r <= {addr_r[23:0], byte_nxt};
               end
               if (byte_cnt_r == 3'h1) begin
                  data1_r <= byte_nxt;
               end
               if (byte_cnt_r == 3'h2) begin
                  data2_r <= byte_nxt;
               end
               // repeated reads see the live value
               if (rd_active_r) begin
                  out_sh_r <= rd_sel_r ? sr2 : sr1;
               end
            end
         end else if (sclk_fall && rd_active_r) begin
            miso_r <= out_sh_r[7];
            out_sh_r <= {out_sh_r[6:0], 1'b0};
         end
         miso_oe_r <= rd_active_r;
      end
   end

   // instruction acceptance
   always @(posedge clk_sys) begin
      op_start_r <= 1'b0;
      suspend_r <= 1'b0;
      lock_set_all <= 1'b0;
      lock_unlock <= 1'b0;
      lock_lock <= 1'b0;
      if (!rstn) begin
         state_r <= ST_OFF;
         pu_lock_r <= 1'b1;
         pu_cnt_r <= 32'h0000_0000;
         wel_r <= 1'b0;
         bp_r <= `BP_RESET;
         tb_r <= `TB_RESET;
         cmp_r <= `CMP_RESET;
         qe_r <= `QE_RESET;
         {srp_high_r, srp_low_r} <= `SRP_RESET;
         rst_armed_r <= 1'b0;
         op_kind_r <= `KIND_PROG;
         op_addr_r <= 32'h0000_0000;
      end else if (!vcc_s) begin
         // brown-out: volatile state returns to power-on values
         state_r <= ST_OFF; // RL1
         pu_lock_r <= 1'b1;
         pu_cnt_r <= 32'h0000_0000;
         wel_r <= 1'b0; // RL3
         rst_armed_r <= 1'b0;
         lock_set_all <= 1'b1; // RL9
         if (srp == 2'h2) begin
            {srp_high_r, srp_low_r} <= `SRP_RESET; // RL21
         end
      end else begin
         if (pu_lock_r) begin
            if (pu_cnt_r == PU_LAST) begin
               pu_lock_r <= 1'b0; // RL2
            end else begin
               pu_cnt_r <= pu_cnt_r + 32'h0000_0001;
            end
         end
         case (state_r)
            ST_OFF: begin
               state_r <= ST_READY;
            end
            ST_BUSY: begin
               if (op_done) begin
                  state_r <= ST_READY; // RL14
                  wel_r <= 1'b0; // RL5 RL15
               end
               if (cmd_end && opcode_r == `OP_SUSPEND) begin
                  suspend_r <= 1'b1; // RL13
               end
            end
            ST_SLEEP: begin
               if (cmd_end && opcode_r == `OP_PWR_RELEASE) begin
                  state_r <= ST_READY; // RL6
               end
            end
            default: begin
               if (cmd_end) begin
                  rst_armed_r <= (opcode_r == `OP_RST_ENABLE) && (byte_cnt_r == 3'h1);
                  op_addr_r <= addr_r;
                  if (opcode_r == `OP_WR_ENABLE) begin
                     if (!pu_lock_r) begin
                        wel_r <= 1'b1; // RL2 RL15
                     end
                  end else if (opcode_r == `OP_WR_DISABLE) begin
                     wel_r <= 1'b0; // RL15
                  end else if (opcode_r == `OP_WR_STAT) begin
                     // a refused write keeps every field as it was
                     if (!pu_lock_r && sr_write_ok && byte_cnt_r >= 3'h2) begin // RL24
                        bp_r <= data1_r[`SR1_BP_HI:`SR1_BP_LO]; // RL16
                        tb_r <= data1_r[`SR1_TB]; // RL17
                        srp_low_r <= data1_r[`SR1_SRP_LOW];
                        if (byte_cnt_r >= 3'h3) begin
                           srp_high_r <= data2_r[`SR2_SRP_HIGH];
                           qe_r <= data2_r[`SR2_QE];
                           cmp_r <= data2_r[`SR2_CMP]; // RL18
                        end
                        op_start_r <= 1'b1;
                        op_kind_r <= `KIND_STAT_WRITE;
                        state_r <= ST_BUSY; // RL13
                     end
                  end else if (opcode_r == `OP_PAGE_PROG || opcode_r == `OP_SECT_ERASE ||
                               opcode_r == `OP_BLK_ERASE) begin
                     if (!pu_lock_r && wel_r && has_addr && !region_prot) begin // RL4 RL8 RL24
                        op_start_r <= 1'b1;
                        op_kind_r <= (opcode_r == `OP_PAGE_PROG) ? `KIND_PROG :
                                     (opcode_r == `OP_SECT_ERASE) ? `KIND_SECT_ERASE :
                                     `KIND_BLK_ERASE;
                        state_r <= ST_BUSY;
                     end
                  end else if (opcode_r == `OP_CHIP_ERASE) begin
                     if (!pu_lock_r && wel_r && !chip_prot) begin // RL4 RL11 RL24
                        op_start_r <= 1'b1;
                        op_kind_r <= `KIND_CHIP_ERASE;
                        state_r <= ST_BUSY;
                     end
                  end else if (opcode_r == `OP_SEC_ERASE || opcode_r == `OP_SEC_PROG) begin
                     if (wel_r && has_addr) begin
                        op_start_r <= 1'b1;
                        op_kind_r <= (opcode_r == `OP_SEC_ERASE) ? `KIND_SEC_ERASE :
                                     `KIND_SEC_PROG;
                        state_r <= ST_BUSY;
                     end
                  end else if (opcode_r == `OP_BLK_UNLOCK) begin
                     if (wel_r && has_addr) begin
                        lock_unlock <= 1'b1; // RL10
                     end
                  end else if (opcode_r == `OP_BLK_LOCK) begin
                     if (wel_r && has_addr) begin
                        lock_lock <= 1'b1;
                     end
                  end else if (opcode_r == `OP_PWR_DOWN) begin
                     state_r <= ST_SLEEP; // RL6
                  end else if (opcode_r == `OP_RST_DEVICE) begin
                     if (rst_armed_r) begin
                        wel_r <= 1'b0;
                        lock_set_all <= 1'b1; // RL23
                     end
                  end
               end
            end
         endcase
      end
   end

   // registered copies for the outputs
   always @(posedge clk_sys) begin
      if (!rstn) begin
         status_one_r <= 8'h00;
         status_two_r <= 8'h00;
      end else begin
         status_one_r <= sr1;
         status_two_r <= sr2;
      end
   end

   assign miso = miso_r;
   assign miso_oe = miso_oe_r;
   assign op_start = op_start_r;
   assign op_kind = op_kind_r;
   assign op_addr = op_addr_r;
   assign suspend_req = suspend_r;
   assign busy = status_one_r[`SR1_BUSY];
   assign status_one = status_one_r;
   assign status_two = status_two_r;

endmodule

// >>> inc/flash_wp_defines.vh
`ifndef FLASH_WP_DEFINES_VH
`define FLASH_WP_DEFINES_VH

// instruction codes
`define OP_WR_ENABLE 8'h06
`define OP_WR_DISABLE 8'h04
`define OP_RD_STAT1 8'h05
`define OP_RD_STAT2 8'h35
`define OP_WR_STAT 8'h01
`define OP_PAGE_PROG 8'h02
`define OP_SECT_ERASE 8'h20
`define OP_BLK_ERASE 8'hD8
`define OP_CHIP_ERASE 8'hC7
`define OP_PWR_DOWN 8'hB9
`define OP_PWR_RELEASE 8'hAB
`define OP_BLK_UNLOCK 8'h39
`define OP_BLK_LOCK 8'h36
`define OP_SUSPEND 8'h75
`define OP_SEC_ERASE 8'h44
`define OP_SEC_PROG 8'h42
`define OP_RST_ENABLE 8'h66
`define OP_RST_DEVICE 8'h99

// status_one / status_two field positions
`define SR1_BUSY 0
`define SR1_WEL 1
`define SR1_BP_LO 2
`define SR1_BP_HI 5
`define SR1_TB 6
`define SR1_SRP_LOW 7
`define SR2_SRP_HIGH 0
`define SR2_QE 1
`define SR2_CMP 6

// factory defaults of the writable fields
`define BP_RESET 4'h0
`define TB_RESET 1'b0
`define CMP_RESET 1'b0
`define QE_RESET 1'b0
`define SRP_RESET 2'h0

// operation kinds handed to the array engine
`define KIND_PROG 3'h0
`define KIND_SECT_ERASE 3'h1
`define KIND_BLK_ERASE 3'h2
`define KIND_CHIP_ERASE 3'h3
`define KIND_STAT_WRITE 3'h4
`define KIND_SEC_ERASE 3'h5
`define KIND_SEC_PROG 3'h6

// array geometry
`define LOCK_BITS 542
`define LOCK_IDX_W 10
`define TOP_BLOCK 9'h1FF

// timing
`define CLK_SYS_MHZ 100
`define PU_WRITE_DELAY_US 10
`define PU_WRITE_DELAY_CYC (`PU_WRITE_DELAY_US * `CLK_SYS_MHZ)

`endif

// >>> rtl/block_lock_store.v
`timescale 1ns/1ps
`include "flash_wp_defines.vh"

module block_lock_store (
   input wire clk_sys, // system clock
   input wire rstn, // synchronous reset, active low
   input wire set_all, // lock every region
   input wire unlock, // clear lock of addressed region
   input wire lock, // set lock of addressed region
   input wire [24:0] addr, // byte address inside the array
   output wire locked, // addressed region is locked
   output wire any_locked // some region is locked
);

   reg [`LOCK_BITS-1:0] lock_mem_r;

   // end blocks are split into 4KB sectors, inner blocks take one bit each
   function [`LOCK_IDX_W-1:0] lock_index;
      input [24:0] a;
      begin
         if (a[24:16] == 9'h000) begin
            lock_index = {6'h00, a[15:12]};
         end else if (a[24:16] == `TOP_BLOCK) begin
            lock_index = 10'h010 + {6'h00, a[15:12]};
         end else begin
            lock_index = 10'h01F + {1'b0, a[24:16]};
         end
      end
   endfunction

   wire [`LOCK_IDX_W-1:0] idx = lock_index(addr);

   assign locked = lock_mem_r[idx]; // RL8
   assign any_locked = |lock_mem_r;

   always @(posedge clk_sys) begin
      if (!rstn || set_all) begin
         lock_mem_r <= {`LOCK_BITS{1'b1}}; // RL9 RL23
      end else if (unlock) begin
         lock_mem_r[idx] <= 1'b0; // RL10
      end else if (lock) begin
         lock_mem_r[idx] <= 1'b1;
      end
   end

endmodule

// >>> tb/flash_write_protect_status_monitor.sv
`timescale 1ns/1ps
`include "flash_wp_defines.vh"

module flash_write_protect_status_monitor #(
   parameter int PU_DELAY_CYC = 1000
) (
   input logic clk_sys, // system clock
   input logic rstn, // synchronous reset, active low
   input logic supply_ok, // supply above threshold
   input logic wp_n, // write-protect pin
   input logic op_done, // engine finished
   input logic op_start, // operation start pulse
   input logic [2:0] op_kind, // kind of started operation
   input logic busy, // operation in progress
   input logic [7:0] status_one, // live status_one
   input logic [7:0] status_two // live status_two
);
   logic [15:0] up_cnt;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);

   // counts from the pin, ahead of the synchroniser, so it can only be lenient
   always @(posedge clk_sys) begin
      if (!rstn || !supply_ok) begin
         up_cnt <= 16'h0000;
      end else if (up_cnt != 16'hFFFF) begin
         up_cnt <= up_cnt + 16'h0001;
      end
   end

   supply_low_quiet_a:
      assert property (!supply_ok [*6] |-> !op_start && !status_one[1])
      else $error("operation or latch while supply low");
   lockout_hold_a:
      assert property (op_start |-> up_cnt >= PU_DELAY_CYC)
      else $error("operation started inside power-up lockout");
   start_needs_latch_a:
      assert property (op_start |-> status_one[1])
      else $error("operation started without write enable");
   start_sets_busy_a:
      assert property (op_start |=> busy)
      else $error("busy not raised after start");
   busy_blocks_start_a:
      assert property (busy |-> !op_start)
      else $error("operation started while busy");
   done_clears_busy_a:
      assert property (busy && op_done |-> ##[1:4] (!busy && status_one[1:0] == 2'b00))
      else $error("busy or latch left set after done");
   lockdown_refuse_a:
      assert property (status_two[0] |-> !(op_start && op_kind == `KIND_STAT_WRITE))
      else $error("status write accepted under lock-down");
   pin_guard_a:
      assert property ((status_one[7] && !status_two[0] && !status_two[1] && !wp_n) [*8]
         |-> !(op_start && op_kind == `KIND_STAT_WRITE))
      else $error("status write accepted with protect pin low");
   fields_hold_a:
      assert property (up_cnt > 16'h0008 && $changed(status_one[6:2])
         |-> $past(op_start) && $past(op_kind) == `KIND_STAT_WRITE)
      else $error("protect fields changed without status write");
endmodule

bind flash_write_protect_status flash_write_protect_status_monitor #(
   .PU_DELAY_CYC(PU_DELAY_CYC)
) mon (.clk_sys(clk_sys), .rstn(rstn), .supply_ok(supply_ok), .wp_n(wp_n),
   .op_done(op_done), .op_start(op_start), .op_kind(op_kind), .busy(busy),
   .status_one(status_one), .status_two(status_two));

// >>> tb/flash_host_model.sv
`timescale 1ns/1ps

module flash_host_model (
   output logic cs_n, // chip select, active low
   output logic sclk, // link clock, idles low
   output logic mosi, // data to device
   input logic miso, // data from device
   input logic miso_oe // device drives miso
);
   localparam real HALF = 62.5;

   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      mosi = 1'b0;
   end

   // n whole bytes from the top of d, msb first; second byte's readout lands in rd
   task automatic xfer(input int n, input logic [39:0] d, output logic [7:0] rd);
      int i;
      rd = 8'h00;
      cs_n = 1'b0;
      #(HALF);
      for (i = 0; i < 8 * n; i++) begin
         mosi = d[39 - i];
         #(HALF);
         sclk = 1'b1;
         if (i >= 8 && i < 16) rd = {rd[6:0], miso_oe ? miso : 1'bx};
         #(HALF);
         sclk = 1'b0;
      end
      #(HALF);
      cs_n = 1'b1;
      // a released line shows the opposite level, never a stale bit
      mosi = ~mosi;
      #(4 * HALF);
   endtask
endmodule

// >>> tb/flash_write_protect_status_test.sv
`timescale 1ns/1ps
`include "flash_wp_defines.vh"

module flash_write_protect_status_test;
   localparam int PU = 400;
   localparam logic [31:0] NOADR = 32'h0000_0000;
   logic clk_sys, rstn, supply_ok, cs_n, sclk, mosi, wp_n, scheme, op_done;
   logic miso, miso_oe, op_start, suspend_req, busy;
   logic [2:0] op_kind, last_kind;
   logic [31:0] op_addr, last_addr, a;
   logic [7:0] status_one, status_two, rd;
   int mismatches = 0;
   int n_compared = 0;
   int starts = 0;
   int susp = 0;
   int s0;

   flash_write_protect_status #(.PU_DELAY_CYC(PU)) dut (.clk_sys(clk_sys), .rstn(rstn),
      .supply_ok(supply_ok), .cs_n(cs_n), .sclk(sclk), .mosi(mosi), .wp_n(wp_n),
      .protect_scheme_select(scheme), .op_done(op_done), .miso(miso), .miso_oe(miso_oe),
      .op_start(op_start), .op_kind(op_kind), .op_addr(op_addr), .suspend_req(suspend_req),
      .busy(busy), .status_one(status_one), .status_two(status_two));
   flash_host_model host (.cs_n(cs_n), .sclk(sclk), .mosi(mosi), .miso(miso),
      .miso_oe(miso_oe));

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys) begin
      if (op_start === 1'b1) begin
         starts <= starts + 1;
         last_kind <= op_kind;
         last_addr <= op_addr;
      end
      if (suspend_req === 1'b1) susp <= susp + 1;
   end

   function automatic logic blk_ok(input logic tb, input logic cmp, input logic [8:0] blk);
      return !((tb ? blk == 9'h000 : blk == 9'h1FF) ^ cmp);
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic run(input int n, input logic [39:0] d);
      s0 = starts;
      host.xfer(n, d, rd);
      repeat (10) @(negedge clk_sys);
   endtask

   task automatic cmd(input logic [7:0] op);
      run(1, {op, NOADR});
   endtask

   task automatic finish_op;
      for (int k = 0; k < 20 && busy !== 1'b1; k++) @(negedge clk_sys);
      chk(busy, 1, "busy during op");
      op_done = 1'b1;
      @(negedge clk_sys);
      op_done = 1'b0;
      repeat (5) @(negedge clk_sys);
      chk({busy, status_one[1:0]}, 0, "idle after op");
   endtask

   task automatic wop(input int n, input logic [39:0] d, input logic acc, input logic [2:0] k);
      cmd(`OP_WR_ENABLE);
      run(n, d);
      chk(starts - s0, acc, "operation started");
      if (acc) begin
         chk(last_kind, k, "operation kind");
         if (n == 5) chk(last_addr, d[31:0], "operation address");
         finish_op;
      end
   endtask

   task automatic wstat(input logic [7:0] s1, input logic [7:0] s2, input logic acc);
      wop(3, {`OP_WR_STAT, s1, s2, 16'h0000}, acc, `KIND_STAT_WRITE);
   endtask

   task automatic erase(input logic [31:0] ad, input logic acc);
      wop(5, {`OP_SECT_ERASE, ad}, acc, `KIND_SECT_ERASE);
   endtask

   task automatic test_done;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   initial begin
      #600000;
      mismatches++;
      $display("ERROR %0t watchdog expired", $time);
      test_done;
   end

   initial begin
      rstn = 1'b0;
      supply_ok = 1'b1;
      wp_n = 1'b1;
      scheme = 1'b0;
      op_done = 1'b0;
      void'($urandom(32'h9715));
      repeat (12) @(negedge clk_sys);
      rstn = 1'b1;
      repeat (4) @(negedge clk_sys);
      chk({status_two, status_one}, 16'h0000, "reset values");
      cmd(`OP_WR_ENABLE);
      chk(status_one[1], 0, "latch in lockout");
      repeat (PU) @(negedge clk_sys);
      cmd(`OP_WR_ENABLE);
      chk(status_one[1], 1, "latch after enable");
      cmd(`OP_WR_DISABLE);
      chk(status_one[1], 0, "latch after disable");
      run(3, {`OP_WR_STAT, 8'h3C, 8'h40, 16'h0000});
      chk({starts - s0, status_two, status_one}, 0, "write without enable");
      $display("test power-up done");
      for (int i = 0; i < 4; i++) begin
         wstat({1'b0, i[0], 4'h1, 2'b00}, {1'b0, i[1], 6'h00}, 1);
         chk({status_two[6], status_one[6:2]}, {i[1], i[0], 4'h1}, "protect fields");
         for (int j = 0; j < 3; j++) begin
            a[24:16] = (j == 0) ? 9'h1FF : (j == 1) ? 9'h000 : 9'(1 + $urandom_range(509));
            a = {7'h00, a[24:16], 16'($urandom)};
            erase(a, blk_ok(i[0], i[1], a[24:16]));
         end
      end
      $display("test block protect done");
      wstat(8'h00, 8'h00, 1);
      cmd(`OP_WR_ENABLE);
      run(5, {`OP_BLK_ERASE, a});
      chk(starts - s0, 1, "block erase");
      chk(last_kind, `KIND_BLK_ERASE, "block erase kind");
      cmd(`OP_WR_DISABLE);
      chk(status_one[1], 1, "latch held while busy");
      cmd(`OP_SUSPEND);
      chk(susp, 1, "suspend while busy");
      run(2, {`OP_RD_STAT1, NOADR});
      chk(rd, 8'h03, "status read while busy");
      finish_op;
      wop(1, {`OP_CHIP_ERASE, NOADR}, 1, `KIND_CHIP_ERASE);
      wop(5, {`OP_PAGE_PROG, a}, 1, `KIND_PROG);
      $display("test busy done");
      wstat(8'h3C, 8'h00, 1);
      scheme = 1'b1;
      erase(a, 0);
      wop(5, {`OP_BLK_UNLOCK, a}, 0, 3'h0);
      erase(a, 1);
      cmd(`OP_RST_ENABLE);
      cmd(`OP_RST_DEVICE);
      erase(a, 0);
      scheme = 1'b0;
      erase(a, 0);
      $display("test lock scheme done");
      // the refused erase above left the latch set
      cmd(`OP_WR_DISABLE);
      cmd(`OP_PWR_DOWN);
      cmd(`OP_WR_ENABLE);
      chk(status_one[1], 0, "enable in power-down");
      cmd(`OP_PWR_RELEASE);
      cmd(`OP_WR_ENABLE);
      chk(status_one[1], 1, "enable after release");
      cmd(`OP_WR_DISABLE);
      wstat(8'h80, 8'h00, 1);
      wp_n = 1'b0;
      wstat(8'h88, 8'h00, 0);
      wp_n = 1'b1;
      wstat(8'h88, 8'h00, 1);
      run(2, {`OP_RD_STAT1, NOADR});
      chk(rd, 8'h88, "status readout");
      wstat(8'h08, 8'h01, 1);
      wp_n = 1'($urandom);
      wstat(8'h00, 8'h00, 0);
      supply_ok = 1'b0;
      cmd(`OP_WR_ENABLE);
      supply_ok = 1'b1;
      repeat (PU + 20) @(negedge clk_sys);
      chk({status_two[0], status_one[7:1]}, 8'h04, "after power cycle");
      wstat(8'h80, 8'h01, 1);
      wstat(8'h00, 8'h00, 0);
      supply_ok = 1'b0;
      repeat (20) @(negedge clk_sys);
      supply_ok = 1'b1;
      repeat (PU + 20) @(negedge clk_sys);
      wstat(8'h00, 8'h00, 0);
      $display("test status protect done");
      test_done;
   end
endmodule
